// [src/sdram_bank_consts.svh]
// Constants and timing counts of the bank command state machine
// Functional notes
// - Chip select high ignores strobes; all strobes high with select low is a no-operation.
// - Commands decode from row, column, write strobes per the command table.
// - Commands act only when clock enable high now and before, after self-refresh exit.
// - Precharge to an idle bank leaves it idle, acting as no-operation.
// - Row-active bank accepts read, write with or without auto precharge, and precharge.
// - Read burst accepts read, write, burst stop; precharge truncates and starts precharging.
// - Write burst accepts read, write, burst stop; precharge truncates and starts precharging.
// - Burst stop ends the most recent read or write burst without auto precharge, whatever its bank.
// - Bank is idle only after precharge and full precharge period.
// - Bank is row-active only after activate delay with no burst in progress.
// - Precharge enters precharging; idle once precharge period elapses.
// - Activate enters row activating; row-active once activate-to-column delay elapses.
// - Auto-precharge access holds its state until precharge period elapses, then idle.
// - Device returns all idle after refresh, mode load or precharge-all period.
// - With bank n idle, other banks accept whatever their own state allows.
// - With bank n activating, active or precharging, others accept activate, read, write, precharge.
// - With bank n in any burst, others accept activate, read, write, precharge.
// - Read to bank m interrupting a read switches output one read latency later.
// - Auto-precharge burst interrupted by another bank's burst starts its precharge.
// - Read interrupting a write takes effect on registration, data one read latency later.
`ifndef SDRAM_BANK_CONSTS_SVH
`define SDRAM_BANK_CONSTS_SVH

`define CLK_PERIOD_PS          5000
`define PRECHARGE_PERIOD_PS    18000
`define ACT_TO_COL_DELAY_PS    18000
`define REFRESH_CYCLE_TIME_PS  60000
`define MODE_LOAD_DELAY_CLK    2
`define SELF_REF_EXIT_DELAY_PS 70000
`define WRITE_RECOVERY_PS      12000
`define READ_LATENCY_CLK       3
`define BURST_LENGTH_CLK       4
// Least times round up to whole cycles
`define CYC_UP(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PRECHARGE_CYC   `CYC_UP(`PRECHARGE_PERIOD_PS)
`define ACT_TO_COL_CYC  `CYC_UP(`ACT_TO_COL_DELAY_PS)
`define REFRESH_CYC     `CYC_UP(`REFRESH_CYCLE_TIME_PS)
`define SELF_EXIT_CYC   `CYC_UP(`SELF_REF_EXIT_DELAY_PS)
`define WRITE_REC_CYC   `CYC_UP(`WRITE_RECOVERY_PS)
`define AP_BIT          10
`define CNT_W           8

`endif

// [src/sdram_bank_pkg.sv]
// Types of the bank command state machine
`include "sdram_bank_consts.svh"

package sdram_bank_pkg;
  // Nine commands need four bits
  typedef enum logic [3:0] {
    CMD_INHIBIT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_BURST_STOP, CMD_REFRESH, CMD_MODE_LOAD
  } cmd_t;

  typedef enum logic [3:0] {
    BANK_IDLE, BANK_ACTIVATING, BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE,
    BANK_READ_AP, BANK_WRITE_AP, BANK_PRECHARGING
  } bank_state_t;

  typedef enum logic [2:0] {
    DEV_NORMAL, DEV_REFRESHING, DEV_MODE_LOAD, DEV_PRECHARGE_ALL, DEV_SELF_EXIT
  } dev_state_t;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank;
    logic [11:0] addr;
  } cmd_bus_t;

  typedef struct packed {
    bank_state_t state;
    logic [7:0]  cnt;
    logic        ap_pending;
  } bank_t;

  typedef struct packed {
    bank_t [3:0] banks;
    dev_state_t  dev;
    logic [7:0]  dev_cnt;
    logic        cke_prev;
    logic        in_self_ref;
    logic [1:0]  last_burst_bank;
    logic        burst_live;
    logic [`READ_LATENCY_CLK-1:0]   rd_pipe_vld;
    logic [2*`READ_LATENCY_CLK-1:0] rd_pipe_bank;
    logic        dq_out_en;
    logic [1:0]  dq_out_bank;
    logic        cmd_taken;
    logic [3:0]  idle_mask;
    logic        all_idle;
  } fsm_t;
endpackage : sdram_bank_pkg

// [src/sdram_bank_command_fsm.sv]
// Per-bank command decode and state machine of a four-bank synchronous DRAM
`timescale 1ns/10ps
`include "sdram_bank_consts.svh"

module sdram_bank_command_fsm (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     clk_en_i,
  input  wire logic                     cke_i,
  input  wire logic                     self_refresh_exit_i,
  input  wire sdram_bank_pkg::cmd_bus_t cmd_i,
  output logic [15:0]                   bank_state_o,
  output logic [3:0]                    bank_idle_o,
  output logic                          all_idle_o,
  output logic                          dq_out_en_o,
  output logic [1:0]                    dq_out_bank_o,
  output logic                          cmd_taken_o
);
  import sdram_bank_pkg::*;

  localparam logic [7:0] PRE_CYC  = 8'(`PRECHARGE_CYC);
  localparam logic [7:0] ACT_CYC  = 8'(`ACT_TO_COL_CYC);
  localparam logic [7:0] REF_CYC  = 8'(`REFRESH_CYC);
  localparam logic [7:0] MRD_CYC  = 8'(`MODE_LOAD_DELAY_CLK);
  localparam logic [7:0] XSR_CYC  = 8'(`SELF_EXIT_CYC);
  localparam logic [7:0] WR_CYC   = 8'(`WRITE_REC_CYC);
  localparam logic [7:0] BL_CYC   = 8'(`BURST_LENGTH_CLK);
  localparam int         RL_CYC   = `READ_LATENCY_CLK;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic cmd_t decode(input cmd_bus_t c);
    cmd_t r;
    r = CMD_NOP;
    if (c.cs_n)
    begin
      r = CMD_INHIBIT;
    end
    else
    begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'b111: r = CMD_NOP;
        3'b011: r = CMD_ACTIVATE;
        3'b101: r = CMD_READ;
        3'b100: r = CMD_WRITE;
        3'b010: r = CMD_PRECHARGE;
        3'b110: r = CMD_BURST_STOP;
        3'b001: r = CMD_REFRESH;
        3'b000: r = CMD_MODE_LOAD;
        default: r = CMD_NOP;
      endcase
    end
    return r;
  endfunction : decode

  function automatic logic is_burst(input bank_state_t s);
    return (s == BANK_READ) || (s == BANK_WRITE) || (s == BANK_READ_AP) || (s == BANK_WRITE_AP);
  endfunction : is_burst

  fsm_t q;
  fsm_t next_q;
  cmd_t cmd;
  logic live;
  logic all_pre;
  logic [3:0] idle_now;

  assign cmd = decode(cmd_i);
  // Table only applies with enable high at both edges and no device-wide operation or exit pending
  assign live = q.cke_prev && cke_i && (q.dev == DEV_NORMAL);
  assign all_pre = cmd_i.addr[`AP_BIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    next_q.cke_prev = cke_i;
    next_q.cmd_taken = 1'b0;
    idle_now = '0;

    // Read pipe: a read enters the top stage, owns the data one latency on
    next_q.rd_pipe_vld  = q.rd_pipe_vld >> 1;
    next_q.rd_pipe_bank = q.rd_pipe_bank >> 2;
    if (q.rd_pipe_vld[0])
    begin
      next_q.dq_out_en   = 1'b1;
      next_q.dq_out_bank = q.rd_pipe_bank[1:0];
    end

    // Per-bank timers run on every edge with clock enable high, command or not
    for (int i = 0; i < 4; i++)
    begin
      if (q.banks[i].cnt != 8'h00)
      begin
        next_q.banks[i].cnt = q.banks[i].cnt - 8'h01;
      end
      else
      begin
        case (q.banks[i].state)
          BANK_PRECHARGING: next_q.banks[i].state = BANK_IDLE;
          BANK_ACTIVATING:  next_q.banks[i].state = BANK_ROW_ACTIVE;
          BANK_READ, BANK_WRITE:
          begin
            next_q.banks[i].state = BANK_ROW_ACTIVE;
          end
          BANK_READ_AP, BANK_WRITE_AP:
          begin
            if (q.banks[i].ap_pending)
            begin
              next_q.banks[i].ap_pending = 1'b0;
              next_q.banks[i].cnt = PRE_CYC - 8'h01;
            end
            else
            begin
              next_q.banks[i].state = BANK_IDLE;
            end
          end
          default: next_q.banks[i].state = q.banks[i].state;
        endcase
      end
    end

    // Device-wide operations
    case (q.dev)
      DEV_REFRESHING, DEV_MODE_LOAD, DEV_PRECHARGE_ALL, DEV_SELF_EXIT:
      begin
        if (q.dev_cnt != 8'h00)
        begin
          next_q.dev_cnt = q.dev_cnt - 8'h01;
        end
        else
        begin
          next_q.dev = DEV_NORMAL;
          for (int i = 0; i < 4; i++)
          begin
            next_q.banks[i].state = BANK_IDLE;
            next_q.banks[i].cnt = 8'h00;
          end
        end
      end
      default: next_q.dev = DEV_NORMAL;
    endcase

    // Self-refresh exit: hold off commands for the exit delay
    if (q.in_self_ref && self_refresh_exit_i && cke_i && !q.cke_prev)
    begin
      next_q.in_self_ref = 1'b0;
      next_q.dev = DEV_SELF_EXIT;
      next_q.dev_cnt = XSR_CYC - 8'h01;
    end
    else if (q.cke_prev && !cke_i && cmd == CMD_REFRESH && q.all_idle)
    begin
      next_q.in_self_ref = 1'b1;
    end

    if (live)
    begin
      case (cmd)
        CMD_ACTIVATE:
        begin
          if (q.banks[cmd_i.bank].state == BANK_IDLE)
          begin
            next_q.banks[cmd_i.bank].state = BANK_ACTIVATING;
            next_q.banks[cmd_i.bank].cnt = ACT_CYC - 8'h01;
            next_q.cmd_taken = 1'b1;
          end
        end
        CMD_READ, CMD_WRITE:
        begin
          if (q.banks[cmd_i.bank].state inside {BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE})
          begin
            // Interrupted burst elsewhere: plain ends, auto-precharge starts precharge
            for (int i = 0; i < 4; i++)
            begin
              // An auto-precharge bank already precharging keeps its timer
              if (i != int'(cmd_i.bank) && is_burst(q.banks[i].state) &&
                  (q.banks[i].ap_pending || q.banks[i].state inside {BANK_READ, BANK_WRITE}))
              begin
                if (q.banks[i].state == BANK_READ || q.banks[i].state == BANK_WRITE)
                begin
                  next_q.banks[i].state = BANK_ROW_ACTIVE;
                  next_q.banks[i].cnt = 8'h00;
                end
                else
                begin
                  next_q.banks[i].ap_pending = 1'b0;
                  next_q.banks[i].cnt = (q.banks[i].state == BANK_WRITE_AP) ?
                                        WR_CYC + PRE_CYC - 8'h01 : PRE_CYC - 8'h01;
                end
              end
            end
            if (all_pre)
            begin
              next_q.banks[cmd_i.bank].state = (cmd == CMD_READ) ? BANK_READ_AP : BANK_WRITE_AP;
              next_q.banks[cmd_i.bank].ap_pending = 1'b1;
            end
            else
            begin
              next_q.banks[cmd_i.bank].state = (cmd == CMD_READ) ? BANK_READ : BANK_WRITE;
            end
            next_q.banks[cmd_i.bank].cnt = BL_CYC - 8'h01;
            next_q.last_burst_bank = cmd_i.bank;
            next_q.burst_live = 1'b1;
            next_q.cmd_taken = 1'b1;
            if (cmd == CMD_READ)
            begin
              // Earlier reads stay queued, so each burst surfaces in turn
              next_q.rd_pipe_vld[RL_CYC-1] = 1'b1;
              next_q.rd_pipe_bank[2*(RL_CYC-1) +: 2] = cmd_i.bank;
            end
            else
            begin
              // A write takes the data bus at once
              next_q.rd_pipe_vld = '0;
              next_q.dq_out_en = 1'b0;
            end
          end
        end
        CMD_PRECHARGE:
        begin
          if (all_pre)
          begin
            next_q.dev = DEV_PRECHARGE_ALL;
            next_q.dev_cnt = PRE_CYC - 8'h01;
            for (int i = 0; i < 4; i++)
            begin
              next_q.banks[i].state = BANK_PRECHARGING;
              next_q.banks[i].cnt = PRE_CYC - 8'h01;
            end
            next_q.burst_live = 1'b0;
            next_q.cmd_taken = 1'b1;
          end
          else if (q.banks[cmd_i.bank].state inside {BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE})
          begin
            // Truncates a plain read or write burst of this bank
            next_q.banks[cmd_i.bank].state = BANK_PRECHARGING;
            next_q.banks[cmd_i.bank].cnt = PRE_CYC - 8'h01;
            if (q.last_burst_bank == cmd_i.bank)
            begin
              next_q.burst_live = 1'b0;
            end
            next_q.cmd_taken = 1'b1;
          end
          // Idle bank: no state change
        end
        CMD_BURST_STOP:
        begin
          // Stops the latest burst without auto precharge, whichever bank holds it
          if (q.burst_live && (q.banks[q.last_burst_bank].state inside {BANK_READ, BANK_WRITE}))
          begin
            next_q.banks[q.last_burst_bank].state = BANK_ROW_ACTIVE;
            next_q.banks[q.last_burst_bank].cnt = 8'h00;
            next_q.burst_live = 1'b0;
            next_q.dq_out_en = 1'b0;
            next_q.rd_pipe_vld = '0;
            next_q.cmd_taken = 1'b1;
          end
        end
        CMD_REFRESH, CMD_MODE_LOAD:
        begin
          if (q.all_idle)
          begin
            next_q.dev = (cmd == CMD_REFRESH) ? DEV_REFRESHING : DEV_MODE_LOAD;
            next_q.dev_cnt = (cmd == CMD_REFRESH) ? REF_CYC - 8'h01 : MRD_CYC - 8'h01;
            next_q.cmd_taken = 1'b1;
          end
        end
        default: next_q.cmd_taken = 1'b0;
      endcase
    end

    // Data bus released once the owning burst has ended and no read is queued
    if (q.dq_out_en && !is_burst(q.banks[q.dq_out_bank].state) && q.rd_pipe_vld == '0)
    begin
      next_q.dq_out_en = 1'b0;
    end

    for (int i = 0; i < 4; i++)
    begin
      idle_now[i] = (next_q.banks[i].state == BANK_IDLE);
    end
    next_q.idle_mask = idle_now;
    next_q.all_idle = (&idle_now) && (next_q.dev == DEV_NORMAL);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
      q.idle_mask <= 4'hF;
      q.all_idle <= 1'b1;
    end
    else if (clk_en_i)
    begin
      q <= next_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_out
      assign bank_state_o[4*g +: 4] = q.banks[g].state;
    end
  endgenerate
  assign bank_idle_o   = q.idle_mask;
  assign all_idle_o    = q.all_idle;
  assign dq_out_en_o   = q.dq_out_en;
  assign dq_out_bank_o = q.dq_out_bank;
  assign cmd_taken_o   = q.cmd_taken;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_act_taken;
    clk_en_i && live && cmd == CMD_ACTIVATE && q.banks[cmd_i.bank].state == BANK_IDLE;
  endsequence

  property p_inhibit_no_take;
    clk_en_i && cmd_i.cs_n |=> !cmd_taken_o;
  endproperty
  a_inhibit_no_take: assert property (p_inhibit_no_take) else $error("inhibit was taken");

  property p_act_state;
    s_act_taken |=> q.banks[$past(cmd_i.bank)].state == BANK_ACTIVATING;
  endproperty
  a_act_state: assert property (p_act_state) else $error("activate not entered");

  property p_cke_gate;
    clk_en_i && !q.cke_prev |=> !cmd_taken_o;
  endproperty
  a_cke_gate: assert property (p_cke_gate) else $error("command taken with enable low");

  property p_pre_idle;
    clk_en_i && live && cmd == CMD_PRECHARGE && !all_pre && q.banks[cmd_i.bank].state == BANK_IDLE
      |=> q.banks[$past(cmd_i.bank)].state == BANK_IDLE;
  endproperty
  a_pre_idle: assert property (p_pre_idle) else $error("precharge changed idle bank");

  property p_refresh_busy;
    clk_en_i && live && cmd == CMD_REFRESH && q.all_idle |=> q.dev == DEV_REFRESHING && !all_idle_o;
  endproperty
  a_refresh_busy: assert property (p_refresh_busy) else $error("refresh not started");

  property p_idle_mask;
    clk_en_i && q.banks[0].state == BANK_PRECHARGING && q.banks[0].cnt != 8'h00 |=> !bank_idle_o[0];
  endproperty
  a_idle_mask: assert property (p_idle_mask) else $error("bank idle before precharge period");

  property p_read_taken;
    clk_en_i && live && cmd == CMD_READ && q.banks[cmd_i.bank].state == BANK_ROW_ACTIVE |=> cmd_taken_o;
  endproperty
  a_read_taken: assert property (p_read_taken) else $error("read refused in row active");

  property p_stop_ends;
    clk_en_i && live && cmd == CMD_BURST_STOP && q.burst_live && q.banks[q.last_burst_bank].state == BANK_READ
      |=> q.banks[$past(q.last_burst_bank)].state == BANK_ROW_ACTIVE;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("burst stop missed");
endmodule : sdram_bank_command_fsm

// [verification/sdram_ctrl_model.sv]
// Behavioural memory controller that drives the command strobes
`timescale 1ns/10ps

module sdram_ctrl_model (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     req_i,
  input  wire sdram_bank_pkg::cmd_t     req_cmd_i,
  input  wire logic [1:0]               req_bank_i,
  input  wire logic                     req_ap_i,
  output sdram_bank_pkg::cmd_bus_t      cmd_o
);
  import sdram_bank_pkg::*;

  logic [3:0] strobes;

  // ----------------------------------------
  // Strobe encoding, select first
  // ----------------------------------------
  always_comb
  begin
    case (req_cmd_i)
      CMD_ACTIVATE:   strobes = 4'h3;
      CMD_READ:       strobes = 4'h5;
      CMD_WRITE:      strobes = 4'h4;
      CMD_PRECHARGE:  strobes = 4'h2;
      CMD_BURST_STOP: strobes = 4'h6;
      CMD_REFRESH:    strobes = 4'h1;
      CMD_MODE_LOAD:  strobes = 4'h0;
      default:        strobes = 4'h7;
    endcase
  end

  // ----------------------------------------
  // One command cycle, no-operation otherwise
  // ----------------------------------------
  // Idle address and bank change every cycle so stale values never look valid
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmd_o <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, bank: 2'h0, addr: 12'h000};
    end
    else if (req_i && req_cmd_i == CMD_INHIBIT)
    begin
      {cmd_o.cs_n, cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} <= {1'b1, 3'($urandom)};
      cmd_o.bank <= 2'($urandom);
      cmd_o.addr <= 12'($urandom);
    end
    else if (req_i)
    begin
      {cmd_o.cs_n, cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} <= strobes;
      cmd_o.bank <= req_bank_i;
      cmd_o.addr <= (12'($urandom) & 12'hBFF) | {1'b0, req_ap_i, 10'h000};
    end
    else
    begin
      {cmd_o.cs_n, cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} <= 4'h7;
      cmd_o.bank <= 2'($urandom);
      cmd_o.addr <= 12'($urandom);
    end
  end
endmodule : sdram_ctrl_model

// [verification/sdram_bank_command_fsm_test.sv]
// Self-checking bench of the bank command state machine
`timescale 1ns/10ps
`include "sdram_bank_consts.svh"

module sdram_bank_command_fsm_test;
  import sdram_bank_pkg::*;

  logic        clk_i;
  logic        rst_n_i;
  logic        cke_i;
  logic        clk_en;
  logic        sr_exit;
  logic        req;
  cmd_t        req_cmd;
  logic [1:0]  req_bank;
  logic        req_ap;
  cmd_bus_t    cmd_bus;
  logic [15:0] bank_state;
  logic [3:0]  bank_idle;
  logic        all_idle;
  logic        dq_en;
  logic [1:0]  dq_bank;
  logic        taken;
  int          miscompares;
  int          checks;
  int          n;
  logic [1:0]  b;
  logic        ap;
  cmd_t        c;
  cmd_t        dev_cmd[3] = '{CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD};
  int          dev_cyc[3] = '{`PRECHARGE_CYC, `REFRESH_CYC, `MODE_LOAD_DELAY_CLK};

  sdram_ctrl_model i_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .req_cmd_i(req_cmd),
    .req_bank_i(req_bank), .req_ap_i(req_ap), .cmd_o(cmd_bus));

  sdram_bank_command_fsm i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .cke_i(cke_i),
    .self_refresh_exit_i(sr_exit), .cmd_i(cmd_bus), .bank_state_o(bank_state), .bank_idle_o(bank_idle),
    .all_idle_o(all_idle), .dq_out_en_o(dq_en), .dq_out_bank_o(dq_bank), .cmd_taken_o(taken));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [3:0] st(input logic [1:0] bk);
    return bank_state[{bk, 2'b00} +: 4];
  endfunction : st

  function automatic logic [3:0] access_state(input cmd_t cm, input logic a);
    if (cm == CMD_READ)
      return a ? BANK_READ_AP : BANK_READ;
    return a ? BANK_WRITE_AP : BANK_WRITE;
  endfunction : access_state

  function automatic bit hit(input int kind, input logic [1:0] bk, input logic [3:0] s);
    case (kind)
      0:       return taken === 1'b1;
      1:       return dq_en === 1'b1;
      2:       return all_idle === 1'b0;
      default: return st(bk) === s;
    endcase
  endfunction : hit

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic issue(input cmd_t cm, input logic [1:0] bk, input logic a);
    @(posedge clk_i);
    req      <= 1'b1;
    req_cmd  <= cm;
    req_bank <= bk;
    req_ap   <= a;
  endtask : issue

  task automatic release_bus;
    @(posedge clk_i);
    req <= 1'b0;
  endtask : release_bus

  task automatic send(input cmd_t cm, input logic [1:0] bk, input logic a);
    issue(cm, bk, a);
    release_bus();
  endtask : send

  // Bounded wait; running out ends the run
  task automatic wait_for(input int kind, input logic [1:0] bk, input logic [3:0] s);
    int k;
    k = 0;
    tick(1);
    while (!hit(kind, bk, s))
    begin
      k++;
      if (k > 40)
      begin
        miscompares++;
        $display("mismatch wait %0d expected event seen timeout", kind);
        finish_test();
      end
      tick(1);
    end
  endtask : wait_for

  // Cycles for which the condition keeps holding
  task automatic dwell(input int kind, input logic [1:0] bk, input logic [3:0] s);
    n = 1;
    tick(1);
    while (hit(kind, bk, s) && n < 64)
    begin
      n++;
      tick(1);
    end
  endtask : dwell

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial
  begin
    rst_n_i     = 1'b0;
    cke_i       = 1'b1;
    clk_en      = 1'b1;
    sr_exit     = 1'b0;
    req         = 1'b0;
    req_cmd     = CMD_NOP;
    req_bank    = 2'h0;
    req_ap      = 1'b0;
    miscompares = 0;
    checks      = 0;
    void'($urandom(32'hA1E2));
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(3);
    chk("idle mask", 16'h000F, 16'(bank_idle));
    chk("all idle", 16'h0001, 16'(all_idle));
    chk("states", 16'h0000, bank_state);
    end_test("reset");

    send(CMD_ACTIVATE, 2'h0, 1'b0);
    wait_for(0, 2'h0, 4'h0);
    chk("b0 activating", 16'(BANK_ACTIVATING), 16'(st(2'h0)));
    dwell(3, 2'h0, BANK_ACTIVATING);
    chk("activate dwell", 16'(`ACT_TO_COL_CYC), 16'(n));
    chk("b0 active", 16'(BANK_ROW_ACTIVE), 16'(st(2'h0)));
    end_test("activate");

    repeat (8) send(CMD_INHIBIT, 2'h0, 1'b0);
    send(CMD_NOP, 2'h0, 1'b0);
    @(posedge clk_i);
    cke_i <= 1'b0;
    send(CMD_PRECHARGE, 2'h0, 1'b0);
    send(CMD_PRECHARGE, 2'h2, 1'b0);
    tick(3);
    chk("b0 held", 16'(BANK_ROW_ACTIVE), 16'(st(2'h0)));
    @(posedge clk_i);
    cke_i <= 1'b1;
    tick(2);
    send(CMD_PRECHARGE, 2'h2, 1'b0);
    tick(3);
    chk("b2 idle", 16'(BANK_IDLE), 16'(st(2'h2)));
    chk("idle mask", 16'h000E, 16'(bank_idle));
    end_test("deselect");

    issue(CMD_READ, 2'h0, 1'b0);
    issue(CMD_BURST_STOP, 2'h0, 1'b0);
    release_bus();
    tick(2);
    chk("b0 after stop", 16'(BANK_ROW_ACTIVE), 16'(st(2'h0)));
    issue(CMD_WRITE, 2'h0, 1'b0);
    issue(CMD_PRECHARGE, 2'h0, 1'b0);
    release_bus();
    wait_for(3, 2'h0, BANK_PRECHARGING);
    dwell(3, 2'h0, BANK_PRECHARGING);
    chk("precharge dwell", 16'(`PRECHARGE_CYC), 16'(n));
    chk("b0 idle", 16'(BANK_IDLE), 16'(st(2'h0)));
    end_test("burst");

    issue(CMD_ACTIVATE, 2'h0, 1'b0);
    issue(CMD_ACTIVATE, 2'h1, 1'b0);
    release_bus();
    wait_for(3, 2'h1, BANK_ROW_ACTIVE);
    chk("b0 active", 16'(BANK_ROW_ACTIVE), 16'(st(2'h0)));
    for (int i = 0; i < 2; i++)
    begin
      issue(i == 0 ? CMD_READ : CMD_WRITE, 2'h0, 1'b0);
      issue(CMD_READ, 2'h1, 1'b0);
      release_bus();
      wait_for(1, 2'h0, 4'h0);
      if (i == 0)
      begin
        chk("first beat bank", 16'h0000, 16'(dq_bank));
        tick(1);
      end
      chk("switched bank", 16'h0001, 16'(dq_bank));
      wait_for(3, 2'h0, BANK_ROW_ACTIVE);
      wait_for(3, 2'h1, BANK_ROW_ACTIVE);
    end
    end_test("interrupt");

    send(CMD_READ, 2'h1, 1'b1);
    wait_for(3, 2'h1, BANK_READ_AP);
    dwell(3, 2'h1, BANK_READ_AP);
    chk("auto precharge dwell", 16'(`BURST_LENGTH_CLK + `PRECHARGE_CYC), 16'(n));
    chk("b1 idle", 16'(BANK_IDLE), 16'(st(2'h1)));
    end_test("auto precharge");

    for (int k = 0; k < 3; k++)
    begin
      send(dev_cmd[k], 2'h0, 1'b1);
      wait_for(2, 2'h0, 4'h0);
      dwell(2, 2'h0, 4'h0);
      chk("device op time", 16'(dev_cyc[k]), 16'(n));
      chk("idle mask", 16'h000F, 16'(bank_idle));
    end
    end_test("device ops");

    // Refresh with enable low enters self refresh; exit holds off commands
    issue(CMD_REFRESH, 2'h0, 1'b0);
    release_bus();
    cke_i <= 1'b0;
    tick(4);
    chk("self refresh quiet", 16'h0001, 16'(all_idle));
    @(posedge clk_i);
    cke_i   <= 1'b1;
    sr_exit <= 1'b1;
    wait_for(2, 2'h0, 4'h0);
    dwell(2, 2'h0, 4'h0);
    chk("self exit time", 16'(`SELF_EXIT_CYC), 16'(n));
    end_test("self refresh");

    // Clock enable low freezes the activate timer mid-count
    send(CMD_ACTIVATE, 2'h3, 1'b0);
    wait_for(0, 2'h3, 4'h0);
    @(posedge clk_i);
    clk_en  <= 1'b0;
    sr_exit <= 1'b0;
    repeat (6) @(posedge clk_i);
    clk_en <= 1'b1;
    dwell(3, 2'h3, BANK_ACTIVATING);
    chk("frozen activate rest", 16'(`ACT_TO_COL_CYC - 1), 16'(n));
    send(CMD_PRECHARGE, 2'h3, 1'b0);
    wait_for(3, 2'h3, BANK_IDLE);
    end_test("clock enable");

    repeat (6)
    begin
      b  = 2'($urandom);
      ap = 1'($urandom);
      c  = ($urandom % 2) ? CMD_READ : CMD_WRITE;
      send(CMD_ACTIVATE, b, 1'b0);
      wait_for(3, b, BANK_ROW_ACTIVE);
      send(c, b, ap);
      wait_for(0, b, 4'h0);
      chk("access state", 16'(access_state(c, ap)), 16'(st(b)));
      if (!ap)
        send(CMD_PRECHARGE, b, 1'b0);
      wait_for(3, b, BANK_IDLE);
    end
    tick(2);
    chk("all idle", 16'h0001, 16'(all_idle));
    end_test("random");
    finish_test();
  end
endmodule : sdram_bank_command_fsm_test
